// [hdl/task_ctrl_pkg.sv]
// package: bit positions, reset values and enumerations for the task control bit interpreter
package task_ctrl_pkg;
  // register map, word index times four gives the byte address
  localparam logic [3:0]  ADDR_TASK1_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_TASK2_CTRL   = 4'h4;
  localparam logic [3:0]  ADDR_STATUS       = 4'h8;
  localparam logic [3:0]  ADDR_PROG_NUM     = 4'hc;
  localparam logic [15:0] CTRL_RESET        = 16'h0000;
  // control word bit positions
  localparam int BIT_AUTO     = 1;
  localparam int BIT_START    = 2;
  localparam int BIT_FBE      = 4;
  localparam int BIT_PAUSE    = 5;
  localparam int BIT_MRST     = 6;
  localparam int BIT_PRGRD    = 7;
  localparam int BIT_TADDR    = 8;
  localparam int BIT_TEACH    = 9;
  localparam int BIT_TTYPE    = 10;
  localparam int BIT_XMIT     = 11;
  localparam int BIT_RECV     = 12;
  localparam int BIT_FLASH    = 13;
  // auxiliary code boundaries, teach address reset and service length
  localparam logic [9:0]  MCODE_STANDBY_MAX = 10'd499;
  localparam logic [9:0]  MCODE_ZERO        = 10'h000;
  localparam logic [10:0] TADDR_RESET       = 11'h000;
  localparam int          SVC_CYCLES        = 4;
  localparam logic [2:0]  SVC_LAST          = 3'(SVC_CYCLES - 1);

  typedef enum logic [1:0] {
    RUN_IDLE    = 2'b00,
    RUN_ACTIVE  = 2'b01,
    RUN_STOP    = 2'b10,
    RUN_MWAIT   = 2'b11
  } run_state_e;

  typedef enum logic [1:0] {
    SVC_NONE  = 2'b00,
    SVC_WRITE = 2'b01,
    SVC_READ  = 2'b10,
    SVC_FLASH = 2'b11
  } svc_e;

  // per-task status flags
  typedef struct packed {
    logic mem_run;
    logic mstrobe;
    logic taddr_done;
    logic teach_done;
    logic prog_err;
  } task_stat_s;
endpackage

// [hdl/motion_task_control_bits.sv]
// motion task control bit interpreter: two task sequencers and a data service driven by the task 1 word
`timescale 1ns/1ps
module motion_task_control_bits (
  input  wire  logic        clk,            // 40 MHz clock
  input  wire  logic        rst_n,          // synchronous reset, active low
  input  wire  logic [3:0]  addr,           // register byte address
  input  wire  logic [15:0] wdata,          // write data
  input  wire  logic        wr,             // write strobe
  input  wire  logic        rd,             // read strobe
  output logic       [15:0] rdata,          // read data, valid cycle after rd
  input  wire  logic        exp_enable,     // expansion area valid
  input  wire  logic        block_done,     // execution engine finished a block
  input  wire  logic        block_has_code, // current block outputs an aux code
  input  wire  logic [9:0]  block_code,     // that aux code
  input  wire  logic        prog_edited,    // programs were edited
  input  wire  logic [15:0] exp_taddr,      // teaching start address from expansion area
  input  wire  logic [15:0] cmd_pos,        // commanded target position
  input  wire  logic [15:0] fb_pos,         // encoder feedback position
  output logic              axes_decel,     // decelerate running axes (task 1)
  output logic              axes_decel2,    // decelerate running axes (task 2)
  output logic       [9:0]  aux_code,       // task 1 aux code output
  output logic       [9:0]  aux_code2,      // task 2 aux code output
  output logic       [15:0] prog_number,    // program number latched at start
  output logic              prog_restart,   // pulse: run program from first block
  output logic              skip_block,     // pulse: resume from following block
  output logic       [15:0] teach_data,     // stored teach position
  output logic       [10:0] teach_addr,     // current teaching address
  output logic              teach_we,       // pulse: write teach_data at teach_addr
  output task_ctrl_pkg::svc_e svc_active    // data service in progress
);
  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next, prev1_reg, prev2_reg;
  logic [15:0] prog_in_reg;
  logic [15:0] rdata_reg, rdata_next;
  task_ctrl_pkg::task_stat_s st1, st2;
  logic [2:0]  svc_done_reg;
  logic        svc_err_reg;
  logic        twe_reg, taddr_done_reg, teach_done_reg; // teaching flags; the two done flags are also read by the task 1 status

  wire sel_c1 = (addr == task_ctrl_pkg::ADDR_TASK1_CTRL);
  wire sel_c2 = (addr == task_ctrl_pkg::ADDR_TASK2_CTRL);
  wire sel_st = (addr == task_ctrl_pkg::ADDR_STATUS);
  wire sel_pn = (addr == task_ctrl_pkg::ADDR_PROG_NUM);

  assign ctrl1_next = (wr && sel_c1) ? wdata : ctrl1_reg;
  assign ctrl2_next = (wr && sel_c2) ? wdata : ctrl2_reg;

  // status word: task1 flags low, task2 flags next, service done flags high
  wire [15:0] status_word = {svc_err_reg, svc_done_reg, 2'b00, st2, st1};

  // if/else-if decode, unmapped reads return zero
  always_comb begin
    if (!rd) begin
      rdata_next = 16'h0000;
    end else if (sel_c1) begin
      rdata_next = ctrl1_reg;
    end else if (sel_c2) begin
      rdata_next = ctrl2_reg;
    end else if (sel_st) begin
      rdata_next = status_word;
    end else if (sel_pn) begin
      rdata_next = prog_in_reg;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  // bus registers and previous-sample copies for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl1_reg   <= task_ctrl_pkg::CTRL_RESET;
      ctrl2_reg   <= task_ctrl_pkg::CTRL_RESET;
      prev1_reg   <= task_ctrl_pkg::CTRL_RESET;
      prev2_reg   <= task_ctrl_pkg::CTRL_RESET;
      prog_in_reg <= 16'h0000;
      rdata_reg   <= 16'h0000;
    end else begin
      ctrl1_reg   <= ctrl1_next;
      ctrl2_reg   <= ctrl2_next;
      prev1_reg   <= ctrl1_reg;
      prev2_reg   <= ctrl2_reg;
      prog_in_reg <= (wr && sel_pn) ? wdata : prog_in_reg;
      rdata_reg   <= rdata_next;
    end
  end
  assign rdata = rdata_reg;

  // edges from current versus previous sample
  wire [15:0] rise1 = ctrl1_reg & ~prev1_reg;
  wire [15:0] fall1 = ~ctrl1_reg & prev1_reg;
  wire [15:0] rise2 = ctrl2_reg & ~prev2_reg;
  wire [15:0] fall2 = ~ctrl2_reg & prev2_reg;

  // ----------------------------------------------------------------
  // task sequencers
  // ----------------------------------------------------------------
  // one generate covers both tasks so task 2 shares the sequencer logic; only task 1 reports the teach done flags
  logic [1:0] restart_p, skip_p, decel_v;
  logic [9:0] code_v [2];
  task_ctrl_pkg::task_stat_s stv [2];
  logic [15:0] pnum_v [2];

  for (genvar t = 0; t < 2; t++) begin : g_task
    wire [15:0] c = (t == 0) ? ctrl1_reg : ctrl2_reg;
    wire [15:0] r = (t == 0) ? rise1 : rise2;
    wire [15:0] f = (t == 0) ? fall1 : fall2;
    wire auto_m   = c[task_ctrl_pkg::BIT_AUTO];
    wire fbe_go   = auto_m && r[task_ctrl_pkg::BIT_FBE];
    wire pause_go = auto_m && r[task_ctrl_pkg::BIT_PAUSE] && !fbe_go;
    wire start_ok = auto_m && r[task_ctrl_pkg::BIT_START]
                    && !c[task_ctrl_pkg::BIT_FBE] && !c[task_ctrl_pkg::BIT_PAUSE];
    wire mrst_r   = r[task_ctrl_pkg::BIT_MRST];
    wire mrst_f   = f[task_ctrl_pkg::BIT_MRST];

    task_ctrl_pkg::run_state_e state_reg, state_next;
    logic [9:0]  code_reg;
    logic        strobe_reg, skip_reg, edited_reg, err_reg, rst_p, skp_p, decel_reg;
    logic [15:0] pnum_reg;

    // next-state decision for the block sequencer
    always_comb begin
      state_next = state_reg;
      case (state_reg)
        task_ctrl_pkg::RUN_IDLE, task_ctrl_pkg::RUN_STOP: begin
          if (start_ok && !(edited_reg && !c[task_ctrl_pkg::BIT_PRGRD])) begin
            state_next = task_ctrl_pkg::RUN_ACTIVE;
          end
        end
        task_ctrl_pkg::RUN_ACTIVE: begin
          if (!auto_m || fbe_go || pause_go) begin
            state_next = task_ctrl_pkg::RUN_STOP;
          end else if (block_done && block_has_code && !c[task_ctrl_pkg::BIT_MRST]
                       && block_code <= task_ctrl_pkg::MCODE_STANDBY_MAX) begin
            state_next = task_ctrl_pkg::RUN_MWAIT;
          end
        end
        task_ctrl_pkg::RUN_MWAIT: begin
          if (fbe_go || !auto_m) begin
            state_next = task_ctrl_pkg::RUN_STOP;
          end else if (mrst_f && !strobe_reg) begin
            state_next = task_ctrl_pkg::RUN_ACTIVE;
          end
        end
        default: state_next = task_ctrl_pkg::RUN_IDLE;
      endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        state_reg  <= task_ctrl_pkg::RUN_IDLE;
        code_reg   <= task_ctrl_pkg::MCODE_ZERO;
        strobe_reg <= 1'b0;
        skip_reg   <= 1'b0;
        edited_reg <= 1'b0;
        err_reg    <= 1'b0;
        rst_p      <= 1'b0;
        skp_p      <= 1'b0;
        decel_reg  <= 1'b0;
        pnum_reg   <= 16'h0000;
      end else begin
        state_reg <= state_next;
        decel_reg <= (state_next == task_ctrl_pkg::RUN_STOP) && (state_reg != task_ctrl_pkg::RUN_STOP);
        rst_p     <= 1'b0;
        skp_p     <= 1'b0;
        // an idle task has no block to abandon, so a forced end there must not skip a block later
        if (fbe_go && state_reg != task_ctrl_pkg::RUN_IDLE) begin
          skip_reg <= 1'b1;
        end
        if (prog_edited) begin
          edited_reg <= 1'b1;
        end
        if (state_reg != task_ctrl_pkg::RUN_ACTIVE && state_next == task_ctrl_pkg::RUN_ACTIVE
            && state_reg != task_ctrl_pkg::RUN_MWAIT) begin
          if (c[task_ctrl_pkg::BIT_PRGRD]) begin
            pnum_reg   <= prog_in_reg;
            rst_p      <= 1'b1;
            edited_reg <= 1'b0;
            skip_reg   <= 1'b0;
          end else begin
            skp_p    <= skip_reg;
            skip_reg <= 1'b0;
          end
        end
        if (start_ok && edited_reg && !c[task_ctrl_pkg::BIT_PRGRD]) begin
          err_reg <= 1'b1;
        end else if (state_next == task_ctrl_pkg::RUN_ACTIVE) begin
          err_reg <= 1'b0;
        end
        // aux code output; reset clears standby codes, high codes in any mode
        if (block_done && block_has_code && state_reg == task_ctrl_pkg::RUN_ACTIVE
            && !c[task_ctrl_pkg::BIT_MRST]) begin
          code_reg   <= block_code;
          strobe_reg <= 1'b1;
        end else if ((state_reg == task_ctrl_pkg::RUN_MWAIT && (fbe_go || mrst_r))
                     || (mrst_r && code_reg > task_ctrl_pkg::MCODE_STANDBY_MAX)) begin
          code_reg   <= task_ctrl_pkg::MCODE_ZERO;
          strobe_reg <= 1'b0;
        end
      end
    end

    assign restart_p[t] = rst_p;
    assign skip_p[t]    = skp_p;
    assign decel_v[t]   = decel_reg;
    assign code_v[t]    = code_reg;
    assign pnum_v[t]    = pnum_reg;
    assign stv[t]       = '{mem_run:    (state_reg == task_ctrl_pkg::RUN_ACTIVE
                                         || state_reg == task_ctrl_pkg::RUN_MWAIT),
                            mstrobe:    strobe_reg,
                            taddr_done: (t == 0) ? c[task_ctrl_pkg::BIT_TADDR] && taddr_done_reg : 1'b0,
                            teach_done: (t == 0) ? c[task_ctrl_pkg::BIT_TEACH] && teach_done_reg : 1'b0,
                            prog_err:   err_reg};
  end

  assign st1         = stv[0];
  assign st2         = stv[1];
  assign axes_decel  = decel_v[0];
  assign axes_decel2 = decel_v[1];
  assign aux_code    = code_v[0];
  assign aux_code2   = code_v[1];
  assign prog_number = pnum_v[0];
  assign prog_restart = restart_p[0];
  assign skip_block  = skip_p[0];

  // ----------------------------------------------------------------
  // teaching (task 1 word)
  // ----------------------------------------------------------------
  logic [10:0] taddr_reg;
  logic [15:0] tdata_reg;

  // accepted in any mode and even with an error pending
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      taddr_reg      <= task_ctrl_pkg::TADDR_RESET;
      tdata_reg      <= 16'h0000;
      twe_reg        <= 1'b0;
      taddr_done_reg <= 1'b0;
      teach_done_reg <= 1'b0;
    end else begin
      twe_reg <= 1'b0;
      if (rise1[task_ctrl_pkg::BIT_TADDR] && exp_enable) begin
        taddr_reg      <= exp_taddr[10:0];
        taddr_done_reg <= 1'b1;
      end else if (!ctrl1_reg[task_ctrl_pkg::BIT_TADDR]) begin
        taddr_done_reg <= 1'b0;
      end
      if (rise1[task_ctrl_pkg::BIT_TEACH]) begin
        tdata_reg      <= ctrl1_reg[task_ctrl_pkg::BIT_TTYPE] ? fb_pos : cmd_pos;
        twe_reg        <= 1'b1;
        teach_done_reg <= 1'b1;
      end else if (!ctrl1_reg[task_ctrl_pkg::BIT_TEACH]) begin
        teach_done_reg <= 1'b0;
      end
      if (twe_reg) begin
        taddr_reg <= taddr_reg + 11'h001;
      end
    end
  end
  assign teach_data = tdata_reg;
  assign teach_addr = taddr_reg;
  assign teach_we   = twe_reg;

  // ----------------------------------------------------------------
  // data service: write, read, flash, one at a time
  // ----------------------------------------------------------------
  // rising edges are latched as pending so simultaneous requests are not lost
  logic [2:0] pend_reg;
  task_ctrl_pkg::svc_e svc_reg;
  logic [2:0] cnt_reg;
  wire [2:0] new_req = {rise1[task_ctrl_pkg::BIT_FLASH],
                        rise1[task_ctrl_pkg::BIT_RECV] && exp_enable,
                        rise1[task_ctrl_pkg::BIT_XMIT] && exp_enable};
  wire [2:0] req_bits = {ctrl1_reg[task_ctrl_pkg::BIT_FLASH],
                         ctrl1_reg[task_ctrl_pkg::BIT_RECV],
                         ctrl1_reg[task_ctrl_pkg::BIT_XMIT]};
  wire [2:0] avail    = pend_reg | new_req;
  wire task_ctrl_pkg::svc_e pick = avail[0] ? task_ctrl_pkg::SVC_WRITE :
                                   avail[1] ? task_ctrl_pkg::SVC_READ  :
                                   avail[2] ? task_ctrl_pkg::SVC_FLASH : task_ctrl_pkg::SVC_NONE;
  wire svc_end = (svc_reg != task_ctrl_pkg::SVC_NONE) && (cnt_reg == task_ctrl_pkg::SVC_LAST);

  // service sequencer; done flags drop when the host releases the bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_reg     <= 3'b000;
      svc_reg      <= task_ctrl_pkg::SVC_NONE;
      cnt_reg      <= 3'b000;
      svc_done_reg <= 3'b000;
      svc_err_reg  <= 1'b0;
    end else begin
      svc_done_reg <= svc_done_reg & req_bits;
      svc_err_reg  <= rise1[task_ctrl_pkg::BIT_XMIT] && !exp_enable;
      if (svc_reg == task_ctrl_pkg::SVC_NONE) begin
        svc_reg  <= pick;
        cnt_reg  <= 3'b000;
        pend_reg <= avail & ~(3'b001 << (pick - 2'b01)) & {3{pick != task_ctrl_pkg::SVC_NONE}}
                    | (avail & {3{pick == task_ctrl_pkg::SVC_NONE}});
      end else begin
        pend_reg <= pend_reg | new_req;
        cnt_reg  <= cnt_reg + 3'b001;
        if (svc_end) begin
          svc_done_reg[svc_reg - 2'b01] <= 1'b1;
          svc_reg <= task_ctrl_pkg::SVC_NONE;
        end
      end
    end
  end
  assign svc_active = svc_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fbe_stop;
    @(posedge clk) disable iff (!rst_n)
      (g_task[0].state_reg == task_ctrl_pkg::RUN_ACTIVE && g_task[0].fbe_go) |=> g_task[0].state_reg == task_ctrl_pkg::RUN_STOP;
  endproperty
  a_fbe_stop: assert property (p_fbe_stop) else $error("forced end did not stop");
  property p_fbe_blocks;
    @(posedge clk) disable iff (!rst_n)
      (ctrl1_reg[task_ctrl_pkg::BIT_FBE] && g_task[0].state_reg == task_ctrl_pkg::RUN_IDLE) |=> g_task[0].state_reg != task_ctrl_pkg::RUN_ACTIVE;
  endproperty
  a_fbe_blocks: assert property (p_fbe_blocks) else $error("start ran with forced end high");
  property p_pause_blocks;
    @(posedge clk) disable iff (!rst_n)
      (ctrl1_reg[task_ctrl_pkg::BIT_PAUSE] && g_task[0].state_reg != task_ctrl_pkg::RUN_ACTIVE
       && g_task[0].state_reg != task_ctrl_pkg::RUN_MWAIT)
      |=> g_task[0].state_reg == $past(g_task[0].state_reg);
  endproperty
  a_pause_blocks: assert property (p_pause_blocks) else $error("start ran with pause high");
  property p_teach_inc;
    @(posedge clk) disable iff (!rst_n)
      rise1[task_ctrl_pkg::BIT_TEACH] |=> teach_we ##1 teach_addr == $past(teach_addr, 2) + 11'h001;
  endproperty
  a_teach_inc: assert property (p_teach_inc) else $error("teach address not advanced");
  property p_ttype;
    @(posedge clk) disable iff (!rst_n)
      rise1[task_ctrl_pkg::BIT_TEACH] |=> teach_data == ($past(ctrl1_reg[task_ctrl_pkg::BIT_TTYPE]) ? $past(fb_pos) : $past(cmd_pos));
  endproperty
  a_ttype: assert property (p_ttype) else $error("wrong teach source");
  property p_hi_code;
    @(posedge clk) disable iff (!rst_n)
      (rise1[task_ctrl_pkg::BIT_MRST] && aux_code > task_ctrl_pkg::MCODE_STANDBY_MAX && !block_done) |=> aux_code == 10'h000;
  endproperty
  a_hi_code: assert property (p_hi_code) else $error("high code not cleared");
  property p_order;
    @(posedge clk) disable iff (!rst_n)
      (svc_reg == task_ctrl_pkg::SVC_NONE && avail[0]) |=> svc_reg == task_ctrl_pkg::SVC_WRITE;
  endproperty
  a_order: assert property (p_order) else $error("write not served first");
  property p_mode;
    @(posedge clk) disable iff (!rst_n)
      (!ctrl1_reg[task_ctrl_pkg::BIT_AUTO] && g_task[0].state_reg == task_ctrl_pkg::RUN_IDLE) |=> g_task[0].state_reg == task_ctrl_pkg::RUN_IDLE;
  endproperty
  a_mode: assert property (p_mode) else $error("manual mode started program");
endmodule

// [verification/engine_model.sv]
// far-side model: execution engine that reports axis positions
`timescale 1ns/1ps
module engine_model (
  input  wire  logic        clk,        // bench clock
  input  wire  logic [15:0] seed,       // position base chosen by the bench
  input  wire  logic        step,       // bench asks for one finished block
  output logic              block_done, // block finish pulse, one cycle per step
  output logic       [15:0] cmd_pos,    // commanded target position
  output logic       [15:0] fb_pos      // encoder feedback position
);
  // feedback carries a servo deviation so a wrong position source is always visible
  always_ff @(posedge clk) begin
    cmd_pos    <= seed;
    fb_pos     <= seed ^ 16'h00a5;
    block_done <= step;
  end
endmodule

// [verification/testbench.sv]
// self-checking bench for the task control bit interpreter
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, exp_enable = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, exp_taddr = 16'h0000, seed = 16'h0000, rdata, cmd_pos, fb_pos, prog_number;
  logic [15:0] teach_data, lfsr = 16'h003d, v;
  logic [10:0] teach_addr;
  logic [9:0]  aux_code, aux_code2;
  logic [5:0]  seq;
  logic        block_done, teach_we, prog_restart, seen, skip_block, axes_decel, axes_decel2;
  logic        step = 0, code_on = 0, edited = 0;
  logic [9:0]  code_val = 10'h000, c;
  task_ctrl_pkg::svc_e svc_active;
  int          error_cnt = 0, checks = 0;
  always #12.5 clk = ~clk;
  engine_model em (.clk(clk), .seed(seed), .step(step), .block_done(block_done), .cmd_pos(cmd_pos), .fb_pos(fb_pos));
  motion_task_control_bits uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .exp_enable(exp_enable), .block_done(block_done), .block_has_code(code_on),
    .block_code(code_val), .prog_edited(edited), .exp_taddr(exp_taddr), .cmd_pos(cmd_pos), .fb_pos(fb_pos),
    .axes_decel(axes_decel), .axes_decel2(axes_decel2), .aux_code(aux_code), .aux_code2(aux_code2),
    .prog_number(prog_number), .prog_restart(prog_restart), .skip_block(skip_block),
    .teach_data(teach_data), .teach_addr(teach_addr),
    .teach_we(teach_we), .svc_active(svc_active));
  // ----------------------------------------
  // bench helpers
  // ----------------------------------------
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected teach sample: type bit picks feedback, else command
  function automatic logic [15:0] exp_pos(input logic t, input logic [15:0] s);
    return t ? (s ^ 16'h00a5) : s;
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = rdata;
  endtask
  // engine finishes one block that outputs code k; the code register settles on the edge after the pulse
  task automatic blk(input logic [9:0] k);
    @(posedge clk);
    code_val <= k;
    code_on  <= 1'b1;
    step     <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1 `CHK("teach_addr reset", 11'h000, teach_addr)
    rd_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, v);
    `CHK("ctrl reset", task_ctrl_pkg::CTRL_RESET, v)
    rd_reg(4'h2, v);
    `CHK("unmapped", 16'h0000, v)
    // teach address set, then teaching with both position sources
    lfsr = nxt(lfsr);
    exp_taddr <= lfsr & 16'h03ff;
    exp_enable <= 1'b1;
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0001 << task_ctrl_pkg::BIT_TADDR);
    repeat (3) @(posedge clk);
    #1 `CHK("teach_addr set", lfsr[10:0] & 11'h3ff, teach_addr)
    rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("taddr_done", 1'b1, v[2])
    for (int t = 0; t < 2; t++) begin
      lfsr = nxt(lfsr);
      seed <= lfsr;
      wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'(t) << task_ctrl_pkg::BIT_TTYPE);
      v = {5'h00, teach_addr};
      wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, (16'(t) << task_ctrl_pkg::BIT_TTYPE) | 16'h0200);
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
        @(posedge clk); #1 seen = (teach_we === 1'b1);
      end
      `CHK("teach_we", 1'b1, seen)
      `CHK("teach_data", exp_pos(t[0], lfsr), teach_data)
      @(posedge clk); #1 `CHK("teach_addr inc", v[10:0] + 11'h001, teach_addr)
      rd_reg(task_ctrl_pkg::ADDR_STATUS, v); // teach bit still held until the done flag is seen
      `CHK("teach_done", 1'b1, v[1])
    end
    // cycle start refused while pause or forced block end stands
    for (int b = 0; b < 2; b++) begin
      v = 16'h0002 | (16'h0010 << b);
      wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, v);
      wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, v | 16'h0084);
      seen = 1'b0;
      repeat (8) begin
        @(posedge clk); #1 seen = seen | (prog_restart === 1'b1);
      end
      `CHK("start blocked", 1'b0, seen)
    end
    // accepted start with program number read loads the number
    lfsr = nxt(lfsr);
    wr_reg(task_ctrl_pkg::ADDR_PROG_NUM, lfsr);
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0082);
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0086);
    seen = 1'b0;
    for (int i = 0; i < 8 && !seen; i++) begin
      @(posedge clk); #1 seen = (prog_restart === 1'b1);
    end
    `CHK("restart", 1'b1, seen)
    `CHK("prog_number", lfsr, prog_number)
    // forced end while running: axes stop, host holds the bit until memory run drops, restart skips
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0096);
    @(posedge clk); #1 `CHK("axes_decel", 1'b1, axes_decel)
    v = 16'h0010;
    for (int i = 0; i < 8 && v[4]; i++) rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("mem_run fbe", 1'b0, v[4])
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0002);
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0006);
    @(posedge clk); #1 `CHK("skip_block", 1'b1, skip_block)
    // task 2 runs and stops on its own word
    wr_reg(task_ctrl_pkg::ADDR_TASK2_CTRL, 16'h0006);
    rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("task2 run", 1'b1, v[9])
    wr_reg(task_ctrl_pkg::ADDR_TASK2_CTRL, 16'h0016);
    @(posedge clk); #1 `CHK("axes_decel2", 1'b1, axes_decel2)
    rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("task2 stop", 1'b0, v[9])
    // standby code holds the block; host keeps the reset bit up until the strobe drops
    lfsr = nxt(lfsr);
    c = 10'(lfsr[7:0]);
    blk(c);
    `CHK("standby code", c, aux_code)
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0046);
    v = 16'h0008;
    for (int i = 0; i < 8 && v[3]; i++) rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("code cleared", 10'h000, aux_code)
    `CHK("standby", 1'b1, v[4])
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0006);
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0046);
    blk(10'd600);
    `CHK("code suppressed", 10'h000, aux_code)
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0006);
    c = 10'd600 + 10'(lfsr[15:8]);
    blk(c);
    `CHK("high code", c, aux_code)
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0040);
    @(posedge clk); #1 `CHK("high code reset", 10'h000, aux_code)
    `CHK("task2 code", 10'h000, aux_code2)
    // start after an edit without the number read bit is refused with an error
    edited <= 1'b1;
    @(posedge clk);
    edited <= 1'b0;
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0006);
    rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("prog_err", 1'b1, v[0])
    // three services asked at once run one at a time in fixed order
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h0000);
    wr_reg(task_ctrl_pkg::ADDR_TASK1_CTRL, 16'h3800);
    seq = 6'h00;
    v = 16'h0000;
    repeat (40) begin
      @(posedge clk);
      #1 if (svc_active !== task_ctrl_pkg::SVC_NONE && 16'(svc_active) !== v) seq = {seq[3:0], svc_active};
      v = 16'(svc_active);
    end
    `CHK("service order", 6'b01_10_11, seq)
    rd_reg(task_ctrl_pkg::ADDR_STATUS, v);
    `CHK("service done", 3'b111, v[14:12])
    complete_run();
  end
endmodule
